// ### logic/psm_page_if.sv
`timescale 1ns/100ps
interface psm_page_if;
  logic        wrEn;
  logic [4:0]  wrIdx;
  logic [15:0] wrData;
  logic        setW;
  logic [3:0]  setWIdx;
  logic [3:0]  trIdx;
  logic [15:0] trBase;
  logic [15:0] trDesc;
  logic [4:0]  busIdx;
  logic [15:0] busData;
  modport mem (input wrEn, wrIdx, wrData, setW, setWIdx, trIdx, busIdx,
               output trBase, trDesc, busData);
  modport ctl (output wrEn, wrIdx, wrData, setW, setWIdx, trIdx, busIdx,
               input trBase, trDesc, busData);
endinterface

// ### logic/psm_page_mem.sv
`timescale 1ns/100ps
module psm_page_mem (
  input wire logic clk,
  input wire logic rst,
  psm_page_if.mem  pg
);
  import psm_pkg::*;

  // index = {is descriptor, user set, page number}
  logic [15:0] store [32];

  always_ff @(posedge clk) begin
    for (int i = 0; i < 32; i++) begin
      if (rst) begin
        store[i] <= 16'h0000;
      end else if (pg.wrEn && pg.wrIdx == 5'(i)) begin
        // a hardware set in the same cycle as a software write survives
        if (pg.setW && {1'b1, pg.setWIdx} == 5'(i)) begin
          store[i] <= pg.wrData | PDR_WMASK;
        end else begin
          store[i] <= pg.wrData;
        end
      end else if (pg.setW && {1'b1, pg.setWIdx} == 5'(i)) begin
        store[i] <= store[i] | PDR_WMASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pg.trBase  <= 16'h0000;
      pg.trDesc  <= 16'h0000;
      pg.busData <= 16'h0000;
    end else begin
      pg.trBase  <= store[{1'b0, pg.trIdx}];
      pg.trDesc  <= store[{1'b1, pg.trIdx}];
      pg.busData <= store[pg.busIdx];
    end
  end
endmodule

// ### logic/psm_pkg.sv
package psm_pkg;
  // decode patterns, bits 15:6 of the instruction word
  localparam logic [9:0]  OP_TO_PREV   = 10'h036;
  localparam logic [9:0]  OP_FROM_PREV = 10'h035;
  // recast into an ordinary move
  localparam logic [3:0]  OP_MOVE      = 4'h1;
  localparam logic [5:0]  SP_PREDEC    = 6'h26;
  localparam logic [5:0]  SP_POSTINC   = 6'h16;
  localparam logic [5:0]  REG_SP_DIRECT = 6'h06;
  // mode codes in the processor status word
  localparam logic [1:0]  MODE_KERNEL  = 2'h0;
  localparam logic [1:0]  MODE_USER    = 2'h3;
  localparam int          CM_HI        = 15;
  localparam int          PM_HI        = 13;
  // page descriptor fields
  localparam int          PDR_KEY_LO   = 0;
  localparam int          PDR_WFLAG    = 6;
  localparam int          PDR_LEN_LO   = 8;
  localparam logic [2:0]  KEY_NONRES   = 3'h0;
  localparam logic [2:0]  KEY_RDONLY   = 3'h2;
  localparam logic [2:0]  KEY_RDWR     = 3'h6;
  localparam logic [15:0] PDR_WMASK    = 16'h0040;
  localparam logic [15:0] PDR_WRMASK   = 16'h7f07;
  // register indices on the plain port
  localparam logic [5:0]  IDX_PDR_BASE = 6'h10;
  localparam logic [5:0]  IDX_CTRL     = 6'h20;
  localparam logic [5:0]  IDX_STATUS   = 6'h21;
  localparam int          CTRL_ENABLE  = 0;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  // abort cause bits
  localparam int          AB_MODE      = 0;
  localparam int          AB_NONRES    = 1;
  localparam int          AB_RDONLY    = 2;
  localparam int          AB_LENGTH    = 3;
  localparam int          REF_LATENCY  = 2;
  typedef enum logic [1:0] {KIND_NONE, KIND_TO_PREV, KIND_FROM_PREV} psm_kind_t;
endpackage

// ### logic/psm_space_ctrl.sv
// Functional notes
// - a completed write to a writable page sets its written flag by hardware.
// - a read-only page blocks every write reference.
// - pattern 0066 plus six-bit destination decodes as move to previous space.
// - pattern 0065 plus six-bit source decodes as move from previous space.
// - without the management option both moves raise an illegal instruction trap.
// - with management disabled the moves still work, unrelocated and unprotected.
// - status bits 15:14 current mode, 13:12 previous; 00 kernel, 11 user.
// - all translation uses the current mode except the move's final operand.
// - move from previous space runs as a move pushing onto the stack.
// - move to previous space runs as a move popping from the stack.
// - source address calculation fetches go through the current-mode set.
// - the final source read goes through the previous-mode set.
// - source register mode 0 reg 6 uses previous stack pointer, else current.
// - the fetched source word is pushed on the current mode stack.
// - destination address calculation fetches go through the current-mode set.
// - the final destination write goes through the previous-mode set.
// - destination register mode 0 reg 6 writes previous stack pointer, else current.
// - the pop uses the current mode stack, the store the previous space.
// - addresses beyond a short page's length are holes and abort.
// - a selecting mode of 01 or 10 aborts every reference.
// - access key 0 means non-resident; any reference aborts.
// - access key 2 allows reads and fetches, aborts writes.
// - physical address is base plus bits 12:6, low six bits passed through.
`timescale 1ns/100ps
module psm_space_ctrl (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            mgmtPresent,
  input  wire logic [15:0]     processorStatusWord,
  input  wire logic            instrValid,
  input  wire logic [15:0]     instrWord,
  input  wire logic            instrEnd,
  output logic                 decValid,
  output psm_pkg::psm_kind_t   decKind,
  output logic                 illegalTrap,
  output logic [15:0]          recastWord,
  output logic [1:0]           operandSpMode,
  output logic [1:0]           stackSpMode,
  input  wire logic            refValid,
  input  wire logic            refWrite,
  input  wire logic            refFinal,
  input  wire logic [15:0]     refVa,
  output logic                 refDone,
  output logic                 refAbort,
  output logic [3:0]           abortWhy,
  output logic [17:0]          physAddr,
  input  wire logic [5:0]      busAddr,
  input  wire logic [15:0]     busWdata,
  input  wire logic            busWr,
  input  wire logic            busRd,
  output logic [15:0]          busRdata
);
  import psm_pkg::*;

  psm_page_if pg ();

  psm_page_mem u_mem (
    .clk (clk),
    .rst (rst),
    .pg  (pg.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode fields

  logic [1:0] curMode;
  logic [1:0] prevMode;
  assign curMode  = processorStatusWord[CM_HI -: 2];
  assign prevMode = processorStatusWord[PM_HI -: 2];

  ////////////////////////////////////////////////////////////////////////////
  // control register: bit 0 enables relocation and protection

  logic [15:0] ctrlReg;
  logic        mgmtEnable;
  assign mgmtEnable = ctrlReg[CTRL_ENABLE];

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrlReg <= CTRL_RESET;
    end else if (busWr && busAddr == IDX_CTRL) begin
      ctrlReg <= busWdata & 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode and recast

  logic [9:0]  opTop;
  logic [5:0]  opField;
  logic        isToPrev;
  logic        isFromPrev;
  psm_kind_t   activeKind;

  assign opTop      = instrWord[15:6];
  assign opField    = instrWord[5:0];
  assign isToPrev   = opTop == OP_TO_PREV;
  assign isFromPrev = opTop == OP_FROM_PREV;

  always_ff @(posedge clk) begin
    if (rst) begin
      decValid      <= 1'b0;
      decKind       <= KIND_NONE;
      illegalTrap   <= 1'b0;
      recastWord    <= 16'h0000;
      operandSpMode <= MODE_KERNEL;
      stackSpMode   <= MODE_KERNEL;
    end else begin
      decValid    <= instrValid;
      illegalTrap <= 1'b0;
      decKind     <= KIND_NONE;
      if (instrValid && (isToPrev || isFromPrev)) begin
        // the option missing: the core traps instead of executing
        illegalTrap <= !mgmtPresent;
        stackSpMode <= curMode;
        // only the plain register form names the previous stack pointer
        operandSpMode <= (opField == REG_SP_DIRECT) ? prevMode : curMode;
        if (mgmtPresent && isFromPrev) begin
          decKind    <= KIND_FROM_PREV;
          recastWord <= {OP_MOVE, opField, SP_PREDEC};
        end else if (mgmtPresent) begin
          decKind    <= KIND_TO_PREV;
          recastWord <= {OP_MOVE, SP_POSTINC, opField};
        end
      end
    end
  end

  // the kind stays live until the core ends the instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      activeKind <= KIND_NONE;
    end else if (instrValid) begin
      if (mgmtPresent && isFromPrev) begin
        activeKind <= KIND_FROM_PREV;
      end else if (mgmtPresent && isToPrev) begin
        activeKind <= KIND_TO_PREV;
      end else begin
        activeKind <= KIND_NONE;
      end
    end else if (instrEnd) begin
      activeKind <= KIND_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference stage 0: choose the page register set

  logic       usePrev;
  logic [1:0] selMode;
  // address calculation and stack traffic stay in current space
  assign usePrev = refFinal && activeKind != KIND_NONE;
  assign selMode = usePrev ? prevMode : curMode;

  assign pg.trIdx = {selMode == MODE_USER, refVa[15:13]};

  logic        s1Valid;
  logic        s1Write;
  logic        s1Bypass;
  logic        s1BadMode;
  logic [15:0] s1Va;
  logic [3:0]  s1Idx;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1Valid   <= 1'b0;
      s1Write   <= 1'b0;
      s1Bypass  <= 1'b0;
      s1BadMode <= 1'b0;
      s1Va      <= 16'h0000;
      s1Idx     <= 4'h0;
    end else begin
      s1Valid   <= refValid;
      s1Write   <= refWrite;
      s1Bypass  <= !mgmtEnable;
      s1BadMode <= selMode != MODE_KERNEL && selMode != MODE_USER;
      s1Va      <= refVa;
      s1Idx     <= pg.trIdx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference stage 1: check and relocate

  logic [2:0]  key;
  logic [6:0]  pageLen;
  logic [6:0]  block;
  logic [3:0]  why;
  logic        fault;
  logic [11:0] upper;

  assign key     = pg.trDesc[PDR_KEY_LO +: 3];
  assign pageLen = pg.trDesc[PDR_LEN_LO +: 7];
  assign block   = s1Va[12:6];
  assign upper   = pg.trBase[11:0] + {5'h00, block};

  always_comb begin
    why = 4'h0;
    why[AB_MODE]   = s1BadMode;
    why[AB_NONRES] = !s1BadMode && key != KEY_RDONLY && key != KEY_RDWR;
    why[AB_RDONLY] = !s1BadMode && key == KEY_RDONLY && s1Write;
    why[AB_LENGTH] = !s1BadMode && block > pageLen;
    if (s1Bypass) begin
      why = 4'h0;
    end
  end
  assign fault = |why;

  // only a write that really completes marks the page
  assign pg.setW    = s1Valid && s1Write && !s1Bypass && !fault;
  assign pg.setWIdx = s1Idx;

  always_ff @(posedge clk) begin
    if (rst) begin
      refDone  <= 1'b0;
      refAbort <= 1'b0;
      abortWhy <= 4'h0;
      physAddr <= 18'h00000;
    end else begin
      refDone  <= s1Valid;
      refAbort <= s1Valid && fault;
      abortWhy <= s1Valid ? why : 4'h0;
      if (s1Valid && s1Bypass) begin
        physAddr <= {2'h0, s1Va};
      end else if (s1Valid) begin
        physAddr <= {upper, s1Va[5:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status register: cause of the last abort and the live kind

  logic [3:0] lastWhy;

  always_ff @(posedge clk) begin
    if (rst) begin
      lastWhy <= 4'h0;
    end else if (s1Valid && fault) begin
      lastWhy <= why;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port

  logic        rdPage;
  logic        rdLocal;
  logic [15:0] localData;

  assign pg.wrEn   = busWr && !busAddr[5];
  assign pg.wrIdx  = busAddr[4:0];
  assign pg.wrData = busAddr[4] ? (busWdata & PDR_WRMASK) : busWdata;
  assign pg.busIdx = busAddr[4:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      rdPage    <= 1'b0;
      rdLocal   <= 1'b0;
      localData <= 16'h0000;
    end else begin
      rdPage  <= busRd && !busAddr[5];
      rdLocal <= busRd && busAddr[5];
      // unmapped indices read zero
      if (busAddr == IDX_CTRL) begin
        localData <= ctrlReg;
      end else if (busAddr == IDX_STATUS) begin
        localData <= {10'h000, activeKind, lastWhy};
      end else begin
        localData <= 16'h0000;
      end
    end
  end

  assign busRdata = rdPage ? pg.busData : (rdLocal ? localData : 16'h0000);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_ref_latency: assert property (refValid |-> ##2 refDone)
    else $error("reference answer not two cycles later");

  a_wflag_clean: assert property (s1Valid && fault |-> !pg.setW ##1 refAbort)
    else $error("aborted write marked its page");

  a_wflag_set: assert property (
      s1Valid && s1Write && !s1Bypass && !fault |-> pg.setW ##1 (refDone && !refAbort))
    else $error("completed write did not mark its page");

  a_rdonly_write: assert property (
      s1Valid && s1Write && !s1Bypass && !s1BadMode && key == KEY_RDONLY
      |=> refAbort && abortWhy[AB_RDONLY])
    else $error("write to read-only page not aborted");

  a_bad_mode: assert property (
      refValid && mgmtEnable && !usePrev && (curMode == 2'h1 || curMode == 2'h2)
      |-> ##2 refAbort && abortWhy[AB_MODE])
    else $error("illegal mode reference not aborted");

  a_bypass_flat: assert property (
      refValid && !mgmtEnable |-> ##2 !refAbort && physAddr == {2'h0, $past(refVa, 2)})
    else $error("disabled management altered the reference");

  a_trap_absent: assert property (
      instrValid && !mgmtPresent && (isToPrev || isFromPrev)
      |=> illegalTrap && decKind == KIND_NONE)
    else $error("missing option did not trap");

  a_recast_from: assert property (
      instrValid && mgmtPresent && isFromPrev
      |=> decKind == KIND_FROM_PREV && recastWord == {4'h1, $past(opField), 6'h26})
    else $error("move from previous space recast wrong");

  a_recast_to: assert property (
      instrValid && mgmtPresent && isToPrev
      |=> decKind == KIND_TO_PREV && recastWord == {4'h1, 6'h16, $past(opField)})
    else $error("move to previous space recast wrong");

  a_final_prev: assert property (
      refValid && refFinal && activeKind != KIND_NONE
      |-> pg.trIdx[3] == (prevMode == 2'h3))
    else $error("final operand not in previous space");

  a_sp_select: assert property (
      instrValid && isFromPrev && opField != 6'h06
      |=> operandSpMode == $past(curMode))
    else $error("address stack pointer not current mode");

  a_short_page: assert property (
      s1Valid && !s1Bypass && !s1BadMode && block > pageLen
      |=> refAbort && abortWhy[AB_LENGTH])
    else $error("reference past page length not aborted");

  a_phys_form: assert property (
      s1Valid && !s1Bypass |=> physAddr[5:0] == $past(s1Va[5:0]))
    else $error("displacement bits changed by relocation");
endmodule

// ### tb/previous_space_move_control_tb.sv
`timescale 1ns/100ps
module previous_space_move_control_tb;
  import psm_pkg::*;
  logic        clk;
  logic        rst;
  logic        mgmtPresent;
  logic        instrValid;
  logic [15:0] instrWord;
  logic        instrEnd;
  logic [5:0]  busAddr;
  logic [15:0] busWdata;
  logic        busWr;
  logic        busRd;
  logic [15:0] processor_status_register;
  logic        refValid;
  logic        refWrite;
  logic        refFinal;
  logic [15:0] refVa;
  logic        decValid;
  psm_kind_t   decKind;
  logic        illegalTrap;
  logic [15:0] recastWord;
  logic [1:0]  opMode;
  logic [1:0]  stMode;
  logic        refDone;
  logic        refAbort;
  logic [3:0]  abortWhy;
  logic [17:0] physAddr;
  logic [15:0] busRdata;
  logic        rdSeen = 1'b0;
  logic [31:0] lfsr = 32'hc85e;
  logic [31:0] v;
  int          fails = 0;
  int          n_checks = 0;
  logic [63:0] decQ[$];
  logic [63:0] refQ[$];
  logic [63:0] rdQ[$];
  logic [21:0] setup[0:6] = '{{6'h20, 16'h0001}, {6'h00, 16'h0010}, {6'h10, 16'h7f06},
    {6'h08, 16'h0200}, {6'h18, 16'h7f02}, {6'h11, 16'h7f00}, {6'h12, 16'h0006}};

  psm_core_model u_core (.clk(clk), .processor_status_register(processor_status_register), .refValid(refValid), .refWrite(refWrite),
    .refFinal(refFinal), .refVa(refVa));
  psm_space_ctrl u_psm_space_ctrl (.clk(clk), .rst(rst), .mgmtPresent(mgmtPresent),
    .processorStatusWord(processor_status_register), .instrValid(instrValid), .instrWord(instrWord),
    .instrEnd(instrEnd), .decValid(decValid), .decKind(decKind),
    .illegalTrap(illegalTrap), .recastWord(recastWord), .operandSpMode(opMode),
    .stackSpMode(stMode), .refValid(refValid), .refWrite(refWrite), .refFinal(refFinal),
    .refVa(refVa), .refDone(refDone), .refAbort(refAbort), .abortWhy(abortWhy),
    .physAddr(physAddr), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
    .busRd(busRd), .busRdata(busRdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function logic [31:0] nextRand;
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function logic [17:0] pa(input logic [11:0] base, input logic [15:0] va);
    return {base + {5'h0, va[12:6]}, va[5:0]};
  endfunction

  task cmp(input logic [31:0] got, input logic [63:0] e);
    n_checks++;
    if ((got & e[63:32]) !== e[31:0]) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got & e[63:32], e[31:0]);
    end
  endtask
  task chkDec(input logic [63:0] e);
    cmp({9'h0, illegalTrap, decKind, recastWord, opMode, stMode}, e);
  endtask
  task chkRef(input logic [63:0] e);
    cmp({9'h0, refAbort, abortWhy, physAddr}, e);
  endtask
  task chkRd(input logic [63:0] e);
    cmp({16'h0, busRdata}, e);
  endtask
  // a result with no note waiting is itself a mismatch
  task orphan;
    fails++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
  endtask

  always @(posedge clk) begin
    rdSeen <= busRd;
    if (decValid === 1'b1) begin
      if (decQ.size() == 0) orphan();
      else chkDec(decQ.pop_front());
    end
    if (refDone === 1'b1) begin
      if (refQ.size() == 0) orphan();
      else chkRef(refQ.pop_front());
    end
    if (rdSeen === 1'b1) begin
      if (rdQ.size() == 0) orphan();
      else chkRd(rdQ.pop_front());
    end
  end

  task wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    busWr <= 1'b1;
    busAddr <= a;
    busWdata <= d;
    @(posedge clk);
    busWr <= 1'b0;
  endtask
  task rd(input logic [5:0] a, input logic [15:0] e);
    rdQ.push_back({32'h0000ffff, 16'h0, e});
    @(posedge clk);
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge clk);
    busRd <= 1'b0;
  endtask
  task dec(input logic [15:0] w, input logic [22:0] e, input logic [22:0] m);
    decQ.push_back({9'h0, m, 9'h0, e});
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= w;
    @(posedge clk);
    instrValid <= 1'b0;
  endtask
  // physical address is not compared on an aborted reference
  task ref1(input logic w, input logic f, input logic [15:0] va, input logic [3:0] why,
            input logic [17:0] p);
    refQ.push_back({9'h0, (why != 4'h0) ? 23'h7c0000 : 23'h7fffff, 9'h0, |why, why, p});
    u_core.issue(w, f, va);
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    summarize();
  end

  initial begin
    logic [1:0] c;
    logic [1:0] p;
    rst = 1'b1;
    mgmtPresent = 1'b1;
    instrValid = 1'b0;
    instrWord = 16'h0000;
    instrEnd = 1'b0;
    busAddr = 6'h00;
    busWdata = 16'h0000;
    busWr = 1'b0;
    busRd = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(IDX_CTRL, CTRL_RESET);
    for (int i = 0; i < 4; i++) begin
      c = i[1] ? MODE_USER : MODE_KERNEL;
      p = i[0] ? MODE_USER : MODE_KERNEL;
      u_core.setPsw({c, p, 12'h000});
      dec(16'h0d46, {1'b0, KIND_FROM_PREV, OP_MOVE, REG_SP_DIRECT, SP_PREDEC, p, c},
          '1);
      dec(16'h0d86, {1'b0, KIND_TO_PREV, OP_MOVE, SP_POSTINC, REG_SP_DIRECT, p, c},
          '1);
    end
    u_core.setPsw(16'h3000);
    dec(16'h0d4e, {1'b0, KIND_FROM_PREV, OP_MOVE, 6'h0e, SP_PREDEC, 4'h0}, '1);
    dec(16'h0d96, {1'b0, KIND_TO_PREV, OP_MOVE, SP_POSTINC, 6'h16, 4'h0}, '1);
    dec(16'h1234, {1'b0, KIND_NONE, 20'h0}, 23'h780000);
    mgmtPresent <= 1'b0;
    dec(16'h0d46, {1'b1, 18'h0, MODE_USER, 2'h0}, 23'h70000c);
    dec(16'h0d86, {1'b1, 22'h0}, 23'h700000);
    mgmtPresent <= 1'b1;
    $display("test decode done");
    // unmanaged: bad mode and random addresses pass through untouched
    u_core.setPsw(16'h4000);
    repeat (6) begin
      v = nextRand();
      ref1(v[0], v[1], v[31:16], 4'h0, {2'b00, v[31:16]});
    end
    u_core.rest();
    for (int i = 0; i < 7; i++) wr(setup[i][21:16], setup[i][15:0]);
    wr(6'h2a, 16'hffff);
    rd(6'h2a, 16'h0000);
    rd(6'h08, 16'h0200);
    rd(6'h11, 16'h7f00);
    rd(IDX_CTRL, 16'h0001);
    $display("test registers done");
    u_core.setPsw(16'h3000);
    ref1(1'b1, 1'b0, 16'h0042, 4'h0, pa(12'h010, 16'h0042));
    v = nextRand();
    ref1(1'b0, 1'b0, {3'h0, v[12:0]}, 4'h0, pa(12'h010, {3'h0, v[12:0]}));
    ref1(1'b0, 1'b0, 16'h2000, 4'h2, 18'h0);
    ref1(1'b0, 1'b0, 16'h4040, 4'h8, 18'h0);
    ref1(1'b0, 1'b0, 16'h4000, 4'h0, 18'h0);
    u_core.rest();
    rd(6'h10, 16'h7f46);
    dec(16'h0d86, {1'b0, KIND_TO_PREV, 20'h0}, 23'h700000);
    ref1(1'b1, 1'b1, 16'h0004, 4'h4, 18'h0);
    ref1(1'b0, 1'b1, 16'h0080, 4'h0, pa(12'h200, 16'h0080));
    ref1(1'b0, 1'b0, 16'h0080, 4'h0, pa(12'h010, 16'h0080));
    u_core.rest();
    rd(6'h18, 16'h7f02);
    @(posedge clk);
    instrEnd <= 1'b1;
    @(posedge clk);
    instrEnd <= 1'b0;
    ref1(1'b0, 1'b1, 16'h0080, 4'h0, pa(12'h010, 16'h0080));
    u_core.rest();
    $display("test translate done");
    u_core.setPsw(16'h1000);
    dec(16'h0d46, {1'b0, KIND_FROM_PREV, 20'h0}, 23'h700000);
    ref1(1'b0, 1'b0, 16'h0080, 4'h0, pa(12'h010, 16'h0080));
    ref1(1'b0, 1'b1, 16'h0000, 4'h1, 18'h0);
    u_core.rest();
    u_core.setPsw(16'h8000);
    ref1(1'b0, 1'b0, 16'h0000, 4'h1, 18'h0);
    u_core.rest();
    // status: live kind still from-previous, last cause the bad mode
    rd(IDX_STATUS, {10'h000, KIND_FROM_PREV, 4'h1});
    $display("test modes done");
    repeat (4) @(posedge clk);
    if (decQ.size() + refQ.size() + rdQ.size() != 0) orphan();
    summarize();
  end
endmodule

// ### tb/psm_core_model.sv
`timescale 1ns/100ps
// core side: drives the status word and one memory reference per cycle
module psm_core_model (
  input  wire logic   clk,
  output logic [15:0] processor_status_register,
  output logic        refValid,
  output logic        refWrite,
  output logic        refFinal,
  output logic [15:0] refVa
);
  initial begin
    processor_status_register = 16'h0000;
    refValid = 1'b0;
    refWrite = 1'b0;
    refFinal = 1'b0;
    refVa = 16'h0000;
  end
  // both mode fields change together, between references
  task setPsw(input logic [15:0] v);
    @(posedge clk);
    processor_status_register <= v;
  endtask
  // valid stays up so calls may follow each other edge after edge
  task issue(input logic w, input logic f, input logic [15:0] va);
    @(posedge clk);
    refValid <= 1'b1;
    refWrite <= w;
    refFinal <= f;
    refVa <= va;
  endtask
  // released lines show the inverse, never a stale copy
  task rest;
    @(posedge clk);
    refValid <= 1'b0;
    refWrite <= ~refWrite;
    refFinal <= ~refFinal;
    refVa <= ~refVa;
  endtask
endmodule
